// *** logic/adc_phase_seq.sv ***
// Hard-reset sequencing and phase delay timing for six converter channels.
// Assumes the reset pin is asynchronous and modulator bits arrive on CLK_SYS.
//
// Summary of operation
// - Reset pin low holds channels in reset with all-zero output codes.
// - Hard reset clears modulator state and forces quantizer pattern 0011.
// - Hard reset clears every decimation filter and its output buffer.
// - Reset pin returns every configuration and status register to default.
// - Register writes are ignored while the reset pin is low.
// - Serial data and done pins float while the reset pin is low.
// - All channels sample together; only even accumulation windows shift.
// - Odd channels finish and signal done at the same instant.
// - Each pair field is a 12-bit two's complement tick count, sign bit set by OSR.
// - Pair 1/0 hi[11:0], pair 3/2 hi[23:12], pair 5/4 lo[11:0].
// - Even channel is delayed by exactly the programmed tick count.
// - Positive value makes even channel lag, negative makes it lead.
// - Delay step is one decimation tick, scaled by clock and prescaler.
// - After reset, odd done appears OSR/2 ticks after the reference.
// - Odd to even done spacing equals the pair's programmed delay.
// - Usable delay spans -OSR/2 to OSR/2-1 ticks.
// - Any skew register write resets and restarts all channels.
// - Sign bit moves from bit 11 at OSR 4096 to bit 4 at 32.
// - Merge select shows only most lagging enabled done, else all enabled.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module adc_phase_seq #(
  parameter logic [5:0] BASE_DIV = adc_skew_pkg::DM_BASE_DIV
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic RESET_PIN_N,
  input wire adc_skew_pkg::apb_req_s APB_REQ,
  output adc_skew_pkg::apb_rsp_s APB_RSP,
  input wire logic [adc_skew_pkg::NUM_CH-1:0] MOD_BITS,
  input wire logic SER_DATA,
  output logic MOD_CLEAR,
  output logic QUANT_FORCE,
  output logic [adc_skew_pkg::NUM_CH-1:0][3:0] QUANT_PATTERN,
  output logic [adc_skew_pkg::NUM_CH-1:0][adc_skew_pkg::CODE_W-1:0] CH_CODE,
  output logic DONE_PIN_N,
  output logic DONE_PIN_OE_N,
  output logic SDO_PIN,
  output logic SDO_PIN_OE_N
);
  import adc_skew_pkg::*;
  if (BASE_DIV < 6'h01 || BASE_DIV > 6'h07) begin : g_chk
    $error("BASE_DIV must be 1 to 7");
  end
  // ******************************************************
  // Functions
  // ******************************************************
  // Sign bit sits at SIGN_POS_BASE + osr_sel; upper bits copy it
  function automatic logic [TMR_W-1:0] skew_to_ticks(input logic [FIELD_W-1:0] f,
                                                    input logic [2:0] sel);
    int pos;
    logic [TMR_W-1:0] r;
    logic [TMR_W-1:0] fx;
    pos = int'(sel) + SIGN_POS_BASE;
    r = '0;
    fx = TMR_W'(f);
    for (int i = 0; i < TMR_W; i++) begin
      r[i] = (i <= pos) ? fx[i] : fx[pos];
    end
    return r;
  endfunction : skew_to_ticks

  function automatic logic [2:0] most_lagging(input logic [NUM_CH-1:0] en,
                                              input logic [NUM_CH-1:0][TMR_W-1:0] w);
    logic [2:0] best;
    logic found;
    best = 3'h1;
    found = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (en[i] && (!found || w[i] > w[best])) begin
        best = 3'(i);
        found = 1'b1;
      end
    end
    return best;
  endfunction : most_lagging
  // ******************************************************
  // Reset pin synchroniser and sequencer
  // ******************************************************
  logic pin_meta;
  logic pin_sync;
  seq_state_e state;
  seq_state_e next_state;
  logic tick;
  logic go;
  logic cfg_wr;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= RESET_PIN_N;
      pin_sync <= pin_meta;
    end
  end
  assign go = (state == ST_PEND) & tick;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_HARD: begin
        if (pin_sync) begin
          next_state = ST_PEND;
        end
      end
      ST_PEND: begin
        if (go && !cfg_wr) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cfg_wr) begin
          next_state = ST_PEND;
        end
      end
      default: begin
        next_state = ST_HARD;
      end
    endcase
    if (!pin_sync) begin
      next_state = ST_HARD;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_HARD;
    end else begin
      state <= next_state;
    end
  end
  // ******************************************************
  // Registers and APB slave
  // ******************************************************
  logic [WORD_W-1:0] skew_lo;
  logic [WORD_W-1:0] skew_hi;
  logic [2:0] osr_sel;
  logic [1:0] pre_sel;
  logic merge_sel;
  logic [NUM_CH-1:0] ch_en;
  logic [NUM_CH-1:0] done_flags;
  logic [NUM_CH-1:0] flag_set;
  logic addr_ok;
  logic setup;
  logic access;
  logic wr_ok;
  logic rd_status;
  logic [31:0] rd_mux;
  logic [31:0] prdata;
  logic pslverr;
  assign setup = APB_REQ.psel & ~APB_REQ.penable;
  assign access = APB_REQ.psel & APB_REQ.penable;
  assign addr_ok = (APB_REQ.paddr == ADDR_SKEW_LO) | (APB_REQ.paddr == ADDR_SKEW_HI) |
                   (APB_REQ.paddr == ADDR_CTRL) | (APB_REQ.paddr == ADDR_STATUS);
  assign wr_ok = access & APB_REQ.pwrite & addr_ok & (state != ST_HARD);
  assign cfg_wr = wr_ok & (APB_REQ.paddr != ADDR_STATUS);
  assign rd_status = access & ~APB_REQ.pwrite & (APB_REQ.paddr == ADDR_STATUS);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      skew_lo <= SKEW_RESET;
      skew_hi <= SKEW_RESET;
    end else if (state == ST_HARD) begin
      skew_lo <= SKEW_RESET;
      skew_hi <= SKEW_RESET;
    end else if (wr_ok && APB_REQ.paddr == ADDR_SKEW_LO) begin
      skew_lo <= APB_REQ.pwdata[WORD_W-1:0];
    end else if (wr_ok && APB_REQ.paddr == ADDR_SKEW_HI) begin
      skew_hi <= APB_REQ.pwdata[WORD_W-1:0];
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      osr_sel <= OSR_SEL_RESET;
      pre_sel <= PRE_RESET;
      merge_sel <= MERGE_RESET;
      ch_en <= EN_RESET;
    end else if (state == ST_HARD) begin
      osr_sel <= OSR_SEL_RESET;
      pre_sel <= PRE_RESET;
      merge_sel <= MERGE_RESET;
      ch_en <= EN_RESET;
    end else if (wr_ok && APB_REQ.paddr == ADDR_CTRL) begin
      osr_sel <= APB_REQ.pwdata[CTRL_OSR_LSB +: 3];
      pre_sel <= APB_REQ.pwdata[CTRL_PRE_LSB +: 2];
      merge_sel <= APB_REQ.pwdata[CTRL_MERGE_BIT];
      ch_en <= APB_REQ.pwdata[CTRL_EN_LSB +: NUM_CH];
    end
  end
  // Sticky done flags: a set in the clearing read still lands
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      done_flags <= '0;
    end else if (state == ST_HARD) begin
      done_flags <= '0;
    end else begin
      done_flags <= (rd_status ? '0 : done_flags) | flag_set;
    end
  end
  always_comb begin
    rd_mux = 32'h00000000;
    if (APB_REQ.paddr == ADDR_SKEW_LO) begin
      rd_mux[WORD_W-1:0] = skew_lo;
    end else if (APB_REQ.paddr == ADDR_SKEW_HI) begin
      rd_mux[WORD_W-1:0] = skew_hi;
    end else if (APB_REQ.paddr == ADDR_CTRL) begin
      rd_mux[CTRL_OSR_LSB +: 3] = osr_sel;
      rd_mux[CTRL_PRE_LSB +: 2] = pre_sel;
      rd_mux[CTRL_MERGE_BIT] = merge_sel;
      rd_mux[CTRL_EN_LSB +: NUM_CH] = ch_en;
    end else if (APB_REQ.paddr == ADDR_STATUS) begin
      rd_mux[STAT_HARD_BIT] = (state == ST_HARD);
      rd_mux[STAT_RUN_BIT] = (state == ST_RUN);
      rd_mux[STAT_DONE_LSB +: NUM_CH] = done_flags;
    end
  end
  // Answer is prepared in the setup cycle so the access phase needs no wait
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= APB_REQ.pwrite ? 32'h00000000 : rd_mux;
      pslverr <= ~addr_ok | (APB_REQ.pwrite & (state == ST_HARD));
    end
  end
  assign APB_RSP.pready = 1'b1;
  assign APB_RSP.pslverr = pslverr;
  assign APB_RSP.prdata = prdata;
  // ******************************************************
  // Decimation tick from the system clock
  // ******************************************************
  logic [5:0] pre_cnt;
  logic [5:0] div;
  assign div = BASE_DIV << pre_sel;
  assign tick = (pre_cnt >= div - 6'h01);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pre_cnt <= '0;
    end else if (tick) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end
  // ******************************************************
  // Channel timing
  // ******************************************************
  logic [TMR_W-1:0] osr;
  logic [TMR_W-1:0] half;
  logic [NUM_PAIRS-1:0][FIELD_W-1:0] pair_field;
  logic [NUM_CH-1:0][TMR_W-1:0] wait_of;
  logic [NUM_CH-1:0] chan_done;
  logic [NUM_CH-1:0] en_done;
  logic [2:0] lag_idx;
  logic hold;
  assign osr = OSR_BASE << osr_sel;
  assign half = osr >> 1;
  assign pair_field[0] = skew_hi[SKEW_A_LSB +: FIELD_W];
  assign pair_field[1] = skew_hi[SKEW_B_LSB +: FIELD_W];
  assign pair_field[2] = skew_lo[SKEW_C_LSB +: FIELD_W];
  assign hold = (state != ST_RUN);
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    // Odd channels share one origin; even add the signed skew
    assign wait_of[2*p+1] = half;
    assign wait_of[2*p] = half + skew_to_ticks(pair_field[p], osr_sel);
  end
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    skew_chan_filter #(
      .TMR_W(TMR_W),
      .CODE_W(CODE_W)
    ) u_chan (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .hold(hold),
      .start(go),
      .tick(tick),
      .mod_bit(MOD_BITS[c]),
      .first_wait(wait_of[c]),
      .period(osr),
      .code(CH_CODE[c]),
      .done(chan_done[c])
    );
  end
  assign lag_idx = most_lagging(ch_en, wait_of);
  assign en_done = chan_done & ch_en;
  assign flag_set = merge_sel ? (chan_done[lag_idx] ? ch_en : '0) : en_done;
  // ******************************************************
  // Pins
  // ******************************************************
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      DONE_PIN_N <= 1'b1;
      DONE_PIN_OE_N <= 1'b1;
      SDO_PIN <= 1'b0;
      SDO_PIN_OE_N <= 1'b1;
    end else begin
      DONE_PIN_N <= ~(merge_sel ? en_done[lag_idx] : |en_done);
      DONE_PIN_OE_N <= (next_state == ST_HARD);
      SDO_PIN <= SER_DATA;
      SDO_PIN_OE_N <= (next_state == ST_HARD);
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      MOD_CLEAR <= 1'b1;
      QUANT_FORCE <= 1'b1;
      QUANT_PATTERN <= {NUM_CH{QUANT_RESET_PATTERN}};
    end else begin
      MOD_CLEAR <= (next_state == ST_HARD);
      QUANT_FORCE <= (next_state == ST_HARD);
      QUANT_PATTERN <= {NUM_CH{QUANT_RESET_PATTERN}};
    end
  end
  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  logic [TMR_W-1:0] tick_idx;
  logic first_odd;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      tick_idx <= '0;
      first_odd <= 1'b0;
    end else if (go) begin
      tick_idx <= '0;
      first_odd <= 1'b1;
    end else begin
      if (tick && state == ST_RUN) begin
        tick_idx <= tick_idx + TMR_W'(1);
      end
      if (chan_done[1]) begin
        first_odd <= 1'b0;
      end
    end
  end
  AST_ZERO_CODE: assert property (state == ST_HARD && $past(state == ST_HARD) |-> CH_CODE == '0)
    else $error("codes not zero in hard reset");
  AST_QUANT: assert property (state == ST_HARD |-> MOD_CLEAR && QUANT_FORCE &&
    QUANT_PATTERN == {NUM_CH{4'h3}})
    else $error("quantizer not forced in hard reset");
  AST_DEFAULTS: assert property (state == ST_HARD |=> skew_lo == '0 && skew_hi == '0 &&
    osr_sel == 3'h3 && merge_sel && ch_en == 6'h3F)
    else $error("registers not at default after hard reset");
  AST_WR_IGNORED: assert property (state == ST_HARD && access && APB_REQ.pwrite |=>
    $stable(skew_hi) && $stable(skew_lo))
    else $error("write took effect in hard reset");
  AST_TRISTATE: assert property (state == ST_HARD |-> DONE_PIN_OE_N && SDO_PIN_OE_N)
    else $error("pins driven in hard reset");
  AST_ODD_ALIGN: assert property (chan_done[1] == chan_done[3] && chan_done[3] == chan_done[5])
    else $error("odd channels out of step");
  AST_FIRST_ODD: assert property (chan_done[1] && first_odd |-> tick_idx == half)
    else $error("first odd done not at half OSR");
  AST_RANGE: assert property (wait_of[0] < osr && wait_of[2] < osr && wait_of[4] < osr)
    else $error("skew outside usable range");
  AST_RESTART: assert property (cfg_wr && pin_sync |=> state == ST_PEND ##[1:64] $rose(state == ST_RUN))
    else $error("skew write did not restart channels");
  AST_MERGE: assert property (merge_sel && |en_done && !chan_done[lag_idx] |=> DONE_PIN_N)
    else $error("non-lagging done shown in merge mode");
  AST_RELEASE_TICK: assert property ($rose(state == ST_RUN) |-> $past(tick))
    else $error("release not aligned to tick");
  COV_RELEASE: cover property ($rose(state == ST_RUN));
  COV_SKEW_RESTART: cover property (cfg_wr && state == ST_RUN);
  COV_MERGE_PULSE: cover property (merge_sel && !DONE_PIN_N);
  COV_LEAD: cover property (chan_done[0] && !chan_done[1] && first_odd);
endmodule : adc_phase_seq

// *** logic/adc_skew_pkg.sv ***
// Constants, field layouts and carrier types for the converter sequencer.
// Assumes a single system clock and an APB master with 32-bit data.
package adc_skew_pkg;
  // ******************************************************
  // Geometry
  // ******************************************************
  localparam int NUM_CH = 6;
  localparam int NUM_PAIRS = 3;
  localparam int FIELD_W = 12;
  localparam int WORD_W = 24;
  localparam int CODE_W = 24;
  localparam int TMR_W = 13;
  localparam int ADDR_W = 8;
  // ******************************************************
  // Register offsets (byte addresses)
  // ******************************************************
  localparam logic [ADDR_W-1:0] ADDR_SKEW_LO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SKEW_HI = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int SKEW_A_LSB = 0;
  localparam int SKEW_B_LSB = 12;
  localparam int SKEW_C_LSB = 0;
  localparam int CTRL_OSR_LSB = 0;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_MERGE_BIT = 8;
  localparam int CTRL_EN_LSB = 16;
  localparam int STAT_HARD_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_DONE_LSB = 8;
  localparam int SIGN_POS_BASE = 4;
  // ******************************************************
  // Reset values and timing counts
  // ******************************************************
  localparam logic [WORD_W-1:0] SKEW_RESET = 24'h000000;
  localparam logic [2:0] OSR_SEL_RESET = 3'h3;
  localparam logic [1:0] PRE_RESET = 2'h0;
  localparam logic MERGE_RESET = 1'b1;
  localparam logic [NUM_CH-1:0] EN_RESET = 6'h3F;
  localparam logic [3:0] QUANT_RESET_PATTERN = 4'h3;
  localparam logic [CODE_W-1:0] ZERO_CODE = 24'h000000;
  localparam logic [TMR_W-1:0] OSR_BASE = 13'h0020;
  localparam logic [5:0] DM_BASE_DIV = 6'h04;
  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [1:0] {
    ST_HARD = 2'b00,
    ST_PEND = 2'b01,
    ST_RUN = 2'b10
  } seq_state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;
endpackage : adc_skew_pkg

// *** logic/skew_chan_filter.sv ***
// One channel's decimation accumulator, output buffer and done timer.
// Assumes start coincides with a decimation tick and hold low afterwards.
`timescale 1ns/10ps
module skew_chan_filter #(
  parameter int TMR_W = 13,
  parameter int CODE_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic start,
  input wire logic tick,
  input wire logic mod_bit,
  input wire logic [TMR_W-1:0] first_wait,
  input wire logic [TMR_W-1:0] period,
  output logic [CODE_W-1:0] code,
  output logic done
);
  if (CODE_W < TMR_W) begin : g_chk
    $error("CODE_W too narrow for accumulator");
  end
  logic running;
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] target;
  logic [TMR_W-1:0] acc;
  logic [TMR_W-1:0] cnt_plus;
  logic hit;
  logic zero_hit;
  assign cnt_plus = cnt + TMR_W'(1);
  assign hit = tick & running & ~start & (cnt_plus == target);
  assign zero_hit = start & (first_wait == '0);
  // ******************************************************
  // Timer and accumulation window
  // ******************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      cnt <= '0;
      target <= '0;
      acc <= '0;
    end else if (start) begin
      running <= 1'b1;
      cnt <= '0;
      target <= zero_hit ? period : first_wait;
      acc <= zero_hit ? '0 : TMR_W'(mod_bit);
    end else if (hold) begin
      running <= 1'b0;
      cnt <= '0;
      acc <= '0;
    end else if (hit) begin
      cnt <= '0;
      target <= period;
      acc <= '0;
    end else if (tick && running) begin
      cnt <= cnt_plus;
      acc <= acc + TMR_W'(mod_bit);
    end
  end
  // Double buffer: result only changes at a done, or clears to zero on hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code <= '0;
      done <= 1'b0;
    end else if (hold && !start) begin
      code <= '0;
      done <= 1'b0;
    end else begin
      done <= hit | zero_hit;
      if (hit | zero_hit) begin
        code <= CODE_W'(acc + TMR_W'(mod_bit));
      end
    end
  end
  // ******************************************************
  // Checks
  // ******************************************************
  logic [TMR_W-1:0] idx;
  logic [TMR_W-1:0] fw_seen;
  logic first_pend;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= '0;
      fw_seen <= '0;
      first_pend <= 1'b0;
    end else if (start) begin
      idx <= '0;
      fw_seen <= first_wait;
      first_pend <= 1'b1;
    end else begin
      if (tick && running) begin
        idx <= idx + TMR_W'(1);
      end
      if (done) begin
        first_pend <= 1'b0;
      end
    end
  end
  AST_FIRST_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    done && first_pend |-> idx == fw_seen)
    else $error("first done not at programmed tick");
  AST_HOLD_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    hold && !start |=> code == '0 && !done)
    else $error("hold did not clear filter output");
endmodule : skew_chan_filter

// *** verification/host_mcu.sv ***
// Host side model: drives the hard-reset pin and reads the done line.
// Assumes a pull-up on the done line while the device floats it.
`timescale 1ns/10ps
module host_mcu (
  input wire logic hold_reset,
  input wire logic done_n,
  input wire logic done_oe_n,
  output logic reset_pin_n,
  output logic done_line_n
);
  // ********
  // Pins
  // ********
  assign reset_pin_n = ~hold_reset;
  // Pull-up wins while the device floats the line
  assign done_line_n = done_oe_n ? 1'b1 : done_n;
endmodule : host_mcu

// *** verification/testbench.sv ***
// Self-checking bench for the converter sequencer, driven over APB.
// Assumes BASE_DIV of 1, so one decimation tick per clock at prescale 0.
`timescale 1ns/10ps
module testbench;
  import adc_skew_pkg::*;
  logic clk, rst_n, hold_rst, rpin_n, dline_n, err, sdo;
  logic ser = 1'b0;
  logic [NUM_CH-1:0] mbits = 6'h2A;
  logic mclr, qf, done_n, done_oe_n, sdo_oe_n;
  logic [NUM_CH-1:0][3:0] qpat;
  logic [NUM_CH-1:0][CODE_W-1:0] code;
  logic [31:0] rd, odd, ev;
  apb_req_s req;
  apb_rsp_s rsp;
  int n_fail, checked, t0, t1, k;
  int pr[6] = '{2, 0, 1, 2, 0, 1};
  int ex[6] = '{5, -7, 15, -16, 16, 3};
  logic [11:0] fld[6] = '{12'h005, 12'hFF9, 12'h00F, 12'h010, 12'h010, 12'h003};
  logic [31:0] pctl[2] = '{32'h002A0000, 32'h00020010};
  adc_phase_seq #(.BASE_DIV(6'h01)) adc_phase_seq_i (.CLK_SYS(clk), .RST_N(rst_n), .RESET_PIN_N(rpin_n),
    .APB_REQ(req), .APB_RSP(rsp), .MOD_BITS(mbits), .SER_DATA(ser), .MOD_CLEAR(mclr), .QUANT_FORCE(qf),
    .QUANT_PATTERN(qpat), .CH_CODE(code), .DONE_PIN_N(done_n), .DONE_PIN_OE_N(done_oe_n), .SDO_PIN(sdo),
    .SDO_PIN_OE_N(sdo_oe_n));
  host_mcu host_mcu_i (.hold_reset(hold_rst), .done_n(done_n), .done_oe_n(done_oe_n), .reset_pin_n(rpin_n),
    .done_line_n(dline_n));
  // ********
  // Tasks
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    ser <= ~ser;
  end
  task summarize;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  task chk_v(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 50) begin
      n_fail++;
      summarize();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    chk_v(rd, exp);
    chk_v(32'(err), 32'(exp_err));
  endtask : rchk
  // Slow edges of a stuck design would hang here, so the wait is capped
  task wait_low(output int t);
    for (t = 1; t <= 400; t++) begin
      @(negedge clk);
      if (dline_n === 1'b0) return;
    end
    n_fail++;
    summarize();
  endtask : wait_low
  // ********
  // Sequence
  // ********
  initial begin
    rst_n = 1'b0;
    hold_rst = 1'b0;
    req = '0;
    n_fail = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk_v(32'({mclr, qf, done_oe_n, sdo_oe_n, sdo ^ ser}), 32'h1);
    rchk(ADDR_SKEW_LO, 32'h0, 1'b0);
    rchk(ADDR_CTRL, 32'h003F0103, 1'b0);
    rchk(8'h10, 32'h0, 1'b1);
    apb(1'b1, ADDR_SKEW_HI, 32'hFFABC123);
    rchk(ADDR_SKEW_HI, 32'h00ABC123, 1'b0);
    hold_rst <= 1'b1;
    repeat (6) @(negedge clk);
    chk_v(32'({mclr, qf}), 32'h3);
    chk_v(32'(qpat === {NUM_CH{4'h3}}), 32'h1);
    chk_v(32'(code === '0), 32'h1);
    chk_v(32'({done_oe_n, sdo_oe_n, dline_n}), 32'h7);
    apb(1'b1, ADDR_SKEW_LO, 32'h000123);
    chk_v(32'(err), 32'h1);
    rchk(ADDR_SKEW_LO, 32'h0, 1'b0);
    rchk(ADDR_SKEW_HI, 32'h0, 1'b0);
    rchk(ADDR_STATUS, 32'h00000001, 1'b0);
    hold_rst <= 1'b0;
    repeat (8) @(posedge clk);
    // Odd channels together, one period apart; prescale doubles it
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      mbits <= k[0] ? 6'h3F : 6'h2A;
      apb(1'b1, ADDR_CTRL, pctl[k]);
      wait_low(t0);
      if (k == 0) chk_v(32'(t0 >= 17 && t0 <= 22), 32'h1);
      wait_low(t1);
      chk_v(32'(t1), 32'(32 * (k + 1)));
      chk_v(32'(code[0]), 32'(32 * k));
      chk_v(32'(code[1]), 32'h20);
    end
    // Host keeps each value in range and restarts by writing
    for (k = 0; k < 6; k++) begin
      apb(1'b1, (pr[k] == 2) ? ADDR_SKEW_LO : ADDR_SKEW_HI, 32'(fld[k]) << ((pr[k] == 1) ? 12 : 0));
      odd = 32'(k == 4) | (32'h1 << (17 + 2 * pr[k]));
      ev = odd ^ (32'h3 << (16 + 2 * pr[k]));
      if (k == 5) ev = odd | 32'h100 | (32'h1 << (16 + 2 * pr[k]));
      apb(1'b1, ADDR_CTRL, odd);
      wait_low(t0);
      apb(1'b1, ADDR_CTRL, ev);
      wait_low(t1);
      chk_v(32'(t1 - t0), 32'(ex[k]));
    end
    rchk(ADDR_STATUS, 32'h00003F02, 1'b0);
    apb(1'b1, ADDR_SKEW_HI, 32'h00003000);
    wait_low(t0);
    chk_v(32'(t0), 32'(t1));
    rchk(ADDR_STATUS, 32'h00000C02, 1'b0);
    summarize();
  end
endmodule : testbench
